// *** hw/flash_ctrl_params.svh ***
// named constants of the serial flash modify and guard control
// assumes it is included by the control modules; it holds defines only
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH

// ********
// instruction codes
// ********
`define OP_QUAD_ENTRY 8'h38
`define OP_QUAD_EXIT 8'hFF
`define OP_UNLOCK 8'h06
`define OP_RELOCK 8'h04
`define OP_RD_STATUS 8'h05
`define OP_CFG_WRITE 8'h01
`define OP_SER_PROG 8'h02
`define OP_QUAD_PROG 8'h32
`define OP_SMALL_WIPE 8'h20
`define OP_MID_WIPE 8'h52
`define OP_LARGE_WIPE 8'hD8
`define OP_CHIP_WIPE_A 8'hC7
`define OP_CHIP_WIPE_B 8'h60
`define OP_SLEEP 8'hB9
`define OP_WAKE 8'hAB
`define OP_OTP_ENTER 8'h3A

// ********
// status byte layout; the BOOT_ bits are positions in the one-time config byte
// ********
`define ST_BUSY 0
`define ST_MODIFY 1
`define ST_GUARD_LO 2
`define ST_GUARD_HI 5
`define ST_LOCK 7
`define BOOT_EN_BIT 3
`define BOOT_GRAN_BIT 4
`define BOOT_SIDE_BIT 6

// ********
// sequence lengths in bytes
// ********
`define LEN_ONE 10'h001
`define LEN_CFG 10'h002
`define LEN_ADDR 10'h004
`define LEN_PROG_MIN 10'h005
`define BYTE_CNT_MAX 10'h3FF
`define PAGE_BYTES 9'h100

// ********
// array geometry, 17-bit byte address
// ********
`define ADDR_W 17
`define PAGE_MASK 17'h000FF
`define SECTOR_MASK 17'h00FFF
`define HALF_BLK_MASK 17'h07FFF
`define BLOCK_MASK 17'h0FFFF
`define ARRAY_TOP 17'h1FFFF
`define HALF_BASE 17'h10000
`define GUARD_NONE 3'h0
`define GUARD_HALF 3'h1

// ********
// clock
// ********
`define CLK_MHZ 100

`endif

// *** hw/flash_ctrl_pkg.sv ***
// types shared by the serial flash control modules
// assumes nothing beyond a SystemVerilog compiler
package flash_ctrl_pkg;

	// kind of array modification handed to the array and the guard check
	typedef enum logic [2:0] {
		op_none,
		op_cfg,
		op_prog,
		op_sector,
		op_half,
		op_block,
		op_chip
	} op_kind_t;

	// internal cycle sequencer
	typedef enum logic [1:0] {
		st_idle,
		st_drain,
		st_wait
	} cycle_state_t;

endpackage : flash_ctrl_pkg

// *** hw/guard_if.sv ***
// carrier between the control module and its guard check
// assumes both ends sit in the same clock domain; signals are combinational
`timescale 1ns/1ns
`include "flash_ctrl_params.svh"
interface guard_if;
	import flash_ctrl_pkg::*;
	op_kind_t op;
	logic [`ADDR_W-1:0] addr;
	logic [3:0] guard;
	logic boot_en;
	logic boot_gran;
	logic boot_side;
	logic refuse;

	modport ctrl (output op, addr, guard, boot_en, boot_gran, boot_side, input refuse);
	modport check (input op, addr, guard, boot_en, boot_gran, boot_side, output refuse);
endinterface : guard_if

// *** hw/region_guard_check.sv ***
// decodes guard code and boot lock into ranges and tests a request against them
// assumes op and addr are stable for the cycle in which refuse is used
`timescale 1ns/1ns
`include "flash_ctrl_params.svh"
module region_guard_check
	import flash_ctrl_pkg::*;
(
	// request and guard settings
	guard_if.check g
);
	logic [`ADDR_W-1:0] mask;
	logic [`ADDR_W-1:0] lo;
	logic [`ADDR_W-1:0] hi;
	logic [`ADDR_W-1:0] plo;
	logic [`ADDR_W-1:0] phi;
	logic [`ADDR_W-1:0] bmask;
	logic [`ADDR_W-1:0] blo;
	logic [`ADDR_W-1:0] bhi;
	logic pset;
	logic hit_guard;
	logic hit_boot;

	// overlap test: a request is refused if any byte it touches is guarded
	always_comb begin
		case (g.op)
			op_prog: mask = `PAGE_MASK;
			op_sector: mask = `SECTOR_MASK;
			op_half: mask = `HALF_BLK_MASK;
			op_block: mask = `BLOCK_MASK;
			default: mask = `ARRAY_TOP;
		endcase
		lo = g.addr & ~mask;
		hi = lo | mask;
		pset = 1'b1;
		plo = '0;
		phi = `ARRAY_TOP;
		if (g.guard[2:0] == `GUARD_NONE) begin
			pset = 1'b0;
		end else if (g.guard[2:0] == `GUARD_HALF) begin
			if (g.guard[3]) begin
				phi = `HALF_BASE - 17'h00001;
			end else begin
				plo = `HALF_BASE;
			end
		end
		bmask = g.boot_gran ? `SECTOR_MASK : `BLOCK_MASK;
		blo = g.boot_side ? '0 : (`ARRAY_TOP & ~bmask);
		bhi = g.boot_side ? bmask : `ARRAY_TOP;
		hit_guard = pset && (lo <= phi) && (hi >= plo);
		hit_boot = g.boot_en && (lo <= bhi) && (hi >= blo);
		g.refuse = (g.op != op_none) && (g.op != op_cfg) && (hit_guard || hit_boot);
	end
endmodule : region_guard_check

// *** hw/serial_flash_write_protect_ctrl.sv ***
// serial flash control: command capture, modify latch, busy cycle, power states, guards
// assumes serial pins are synchronous to sys_clk and the array applies strobes itself
`timescale 1ns/1ns
`include "flash_ctrl_params.svh"
// Functional notes
// - quad entry makes all four pins data lines
// - up to 256 bytes, one page, clears bits
// - wipe sets whole region to ones
// - sector, half block, block, chip wipes timed
// - busy flag set during any internal cycle
// - active while selected or cycle runs, else standby unless in deep sleep
// - sleep ignores all but wake command
// - power-up timer blocks modifying operations
// - modify commands need whole-byte clock counts
// - modify needs the modify-allowed latch set
// - latch clears at power-up and completions
// - guard bits refuse writes to guarded range
// - guard pin locks guard and lock bits outside quad mode
// - guard code to protected range decode
// - boot lock enable permanently locks region
// - boot granule and side select region
// - commands other than status read ignored while internal cycle runs
module serial_flash_write_protect_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int CLK_MHZ = `CLK_MHZ,
	parameter int T_PUW_US = 1000,
	parameter int T_CFG_US = 1000,
	parameter int T_PROG_US = 1000,
	parameter int T_SECTOR_US = 1000,
	parameter int T_HALF_US = 1000,
	parameter int T_BLOCK_US = 1000,
	parameter int T_CHIP_US = 10000
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// serial pins
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	output logic [3:0] dq_out,
	output logic [3:0] dq_oe,
	// array side
	output logic array_strobe,
	output op_kind_t array_op,
	output logic [`ADDR_W-1:0] array_addr,
	output logic [7:0] array_data,
	// state seen from outside
	output logic cycle_ongoing_flag,
	output logic modify_allowed_flag,
	output logic [3:0] region_guard_bits,
	output logic guard_lock_flag,
	output logic all_quad_protocol,
	output logic deep_sleep,
	output logic standby,
	output logic boot_lock_enable,
	output logic boot_lock_granule,
	output logic boot_lock_side,
	output logic cmd_refused
);
	localparam int PUW_CYC = T_PUW_US * CLK_MHZ;
	localparam int CFG_CYC = T_CFG_US * CLK_MHZ;
	localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
	localparam int SECTOR_CYC = T_SECTOR_US * CLK_MHZ;
	localparam int HALF_CYC = T_HALF_US * CLK_MHZ;
	localparam int BLOCK_CYC = T_BLOCK_US * CLK_MHZ;
	localparam int CHIP_CYC = T_CHIP_US * CLK_MHZ;

	if (CLK_MHZ < 1 || PUW_CYC < 1 || CFG_CYC < 1 || PROG_CYC < 1 || SECTOR_CYC < 1 ||
		HALF_CYC < 1 || BLOCK_CYC < 1 || CHIP_CYC < 1) begin : bad_timing
		$error("every timing parameter must give at least one cycle");
	end

	// ****************************************
	// serial capture
	// ****************************************
	logic clk_prev, cs_prev;
	logic [7:0] shift, opcode, cfg_data;
	logic [2:0] bit_pos;
	logic [9:0] byte_cnt;
	logic [23:0] addr;
	logic [7:0] wr_ptr;
	logic [8:0] data_cnt;
	logic next_clk_prev, next_cs_prev;
	logic [7:0] next_shift, next_opcode, next_cfg_data;
	logic [2:0] next_bit_pos;
	logic [9:0] next_byte_cnt;
	logic [23:0] next_addr;
	logic [7:0] next_wr_ptr;
	logic [8:0] next_data_cnt;
	logic [3:0] next_dq_out, next_dq_oe;
	logic [7:0] page_buf [0:255];
	logic buf_we;
	logic [7:0] buf_wdata;
	logic [7:0] sh;
	logic [3:0] pos_sum;
	logic clk_rise, clk_fall, cs_fall, cs_rise, wide, is_prog, busy;
	logic [7:0] status;
	cycle_state_t state;

	assign clk_rise = spi_clk && !clk_prev;
	assign clk_fall = !spi_clk && clk_prev;
	assign cs_fall = !cs_n && cs_prev;
	assign cs_rise = cs_n && !cs_prev;
	assign busy = (state != st_idle);
	assign is_prog = (opcode == `OP_SER_PROG) || (opcode == `OP_QUAD_PROG);
	// the four-line program takes its data a nibble a clock after the address
	assign wide = all_quad_protocol || ((opcode == `OP_QUAD_PROG) && (byte_cnt >= `LEN_ADDR));

	// live status byte so polling sees the cycle end at once
	always_comb begin
		status = 8'h00;
		status[`ST_BUSY] = busy;
		status[`ST_MODIFY] = modify_allowed_flag;
		status[`ST_GUARD_HI:`ST_GUARD_LO] = region_guard_bits;
		status[`ST_LOCK] = guard_lock_flag;
	end

	// shift bits in on rising serial clock, status out on falling
	always_comb begin
		next_clk_prev = spi_clk;
		next_cs_prev = cs_n;
		next_shift = shift;
		next_bit_pos = bit_pos;
		next_byte_cnt = byte_cnt;
		next_opcode = opcode;
		next_addr = addr;
		next_cfg_data = cfg_data;
		next_wr_ptr = wr_ptr;
		next_data_cnt = data_cnt;
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		buf_we = 1'b0;
		buf_wdata = 8'h00;
		sh = 8'h00;
		pos_sum = 4'h0;
		if (cs_n) begin
			next_dq_oe = 4'h0;
		end else if (cs_fall) begin
			next_bit_pos = 3'h0;
			next_byte_cnt = 10'h000;
			next_wr_ptr = 8'h00;
			next_data_cnt = 9'h000;
		end else if (clk_rise) begin
			if (wide) begin
				sh = {shift[3:0], dq_in};
				pos_sum = {1'b0, bit_pos} + 4'h4;
			end else begin
				sh = {shift[6:0], dq_in[0]};
				pos_sum = {1'b0, bit_pos} + 4'h1;
			end
			next_shift = sh;
			next_bit_pos = pos_sum[2:0];
			if (pos_sum[3]) begin
				if (byte_cnt != `BYTE_CNT_MAX) begin
					next_byte_cnt = byte_cnt + 10'h001;
				end
				if (byte_cnt == 10'h000) begin
					next_opcode = sh;
				end else if (byte_cnt < `LEN_ADDR) begin
					next_addr = {addr[15:0], sh};
				end else if (is_prog && !busy) begin
					// past a full page the pointer wraps and overwrites
					buf_we = 1'b1;
					buf_wdata = sh;
					next_wr_ptr = wr_ptr + 8'h01;
					if (data_cnt != `PAGE_BYTES) begin
						next_data_cnt = data_cnt + 9'h001;
					end
				end
				if (byte_cnt == `LEN_ONE) begin
					next_cfg_data = sh;
				end
			end
		end else if (clk_fall && (opcode == `OP_RD_STATUS) && (byte_cnt != 10'h000) &&
			!deep_sleep) begin
			if (all_quad_protocol) begin
				next_dq_out = bit_pos[2] ? status[3:0] : status[7:4];
				next_dq_oe = 4'hF;
			end else begin
				next_dq_out = {2'b00, status[3'h7 - bit_pos], 1'b0};
				next_dq_oe = 4'h2;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			clk_prev <= 1'b0;
			cs_prev <= 1'b1;
			shift <= 8'h00;
			bit_pos <= 3'h0;
			byte_cnt <= 10'h000;
			opcode <= 8'h00;
			addr <= 24'h000000;
			cfg_data <= 8'h00;
			wr_ptr <= 8'h00;
			data_cnt <= 9'h000;
			dq_out <= 4'h0;
			dq_oe <= 4'h0;
		end else begin
			clk_prev <= next_clk_prev;
			cs_prev <= next_cs_prev;
			shift <= next_shift;
			bit_pos <= next_bit_pos;
			byte_cnt <= next_byte_cnt;
			opcode <= next_opcode;
			addr <= next_addr;
			cfg_data <= next_cfg_data;
			wr_ptr <= next_wr_ptr;
			data_cnt <= next_data_cnt;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
		end
	end

	// page buffer holds data until the sequence is known to be whole
	always_ff @(posedge sys_clk) begin
		if (buf_we) begin
			page_buf[wr_ptr] <= buf_wdata;
		end
	end

	// ****************************************
	// guard check
	// ****************************************
	guard_if gif ();
	op_kind_t req_op;

	always_comb begin
		case (opcode)
			`OP_CFG_WRITE: req_op = op_cfg;
			`OP_SER_PROG, `OP_QUAD_PROG: req_op = op_prog;
			`OP_SMALL_WIPE: req_op = op_sector;
			`OP_MID_WIPE: req_op = op_half;
			`OP_LARGE_WIPE: req_op = op_block;
			`OP_CHIP_WIPE_A, `OP_CHIP_WIPE_B: req_op = op_chip;
			default: req_op = op_none;
		endcase
	end

	assign gif.op = req_op;
	assign gif.addr = addr[`ADDR_W-1:0];
	assign gif.guard = region_guard_bits;
	assign gif.boot_en = boot_lock_enable;
	assign gif.boot_gran = boot_lock_granule;
	assign gif.boot_side = boot_lock_side;

	region_guard_check u_check (
		.g(gif)
	);

	// ****************************************
	// command execution and internal cycle
	// ****************************************
	cycle_state_t next_state;
	logic [31:0] cyc_cnt, next_cyc_cnt, puw_cnt, next_puw_cnt;
	logic [8:0] drain_idx, drain_total, next_drain_idx, next_drain_total;
	logic [`ADDR_W-1:0] prog_base, next_prog_base;
	logic puw_done, next_puw_done, otp_mode, next_otp_mode;
	logic next_modify, next_lock, next_quad, next_sleep, next_standby, next_refused;
	logic next_boot_en, next_boot_gran, next_boot_side, next_strobe;
	logic [3:0] next_guard;
	op_kind_t next_array_op;
	logic [`ADDR_W-1:0] next_array_addr;
	logic [7:0] next_array_data;
	logic aligned, may_modify, pin_guarded, start;
	logic [31:0] load_cyc;

	assign aligned = (bit_pos == 3'h0);
	assign may_modify = aligned && modify_allowed_flag && puw_done;
	assign pin_guarded = guard_lock_flag && !dq_in[2] && !all_quad_protocol;

	always_comb begin
		next_state = state;
		next_cyc_cnt = cyc_cnt;
		next_puw_cnt = puw_cnt;
		next_puw_done = puw_done;
		next_drain_idx = drain_idx;
		next_drain_total = drain_total;
		next_prog_base = prog_base;
		next_otp_mode = otp_mode;
		next_modify = modify_allowed_flag;
		next_guard = region_guard_bits;
		next_lock = guard_lock_flag;
		next_quad = all_quad_protocol;
		next_sleep = deep_sleep;
		next_boot_en = boot_lock_enable;
		next_boot_gran = boot_lock_granule;
		next_boot_side = boot_lock_side;
		next_strobe = 1'b0;
		next_array_op = array_op;
		next_array_addr = array_addr;
		next_array_data = array_data;
		next_refused = 1'b0;
		start = 1'b0;
		load_cyc = 32'h00000000;
		// power-up window: no modification until it has run out
		if (!puw_done) begin
			next_puw_cnt = puw_cnt + 32'h00000001;
			next_puw_done = (puw_cnt >= 32'(PUW_CYC - 1));
		end
		case (req_op)
			op_cfg: load_cyc = 32'(CFG_CYC - 1);
			op_prog: load_cyc = 32'(PROG_CYC - 1);
			op_sector: load_cyc = 32'(SECTOR_CYC - 1);
			op_half: load_cyc = 32'(HALF_CYC - 1);
			op_block: load_cyc = 32'(BLOCK_CYC - 1);
			op_chip: load_cyc = 32'(CHIP_CYC - 1);
			default: load_cyc = 32'h00000000;
		endcase
		if (cs_rise && deep_sleep) begin
			if ((opcode == `OP_WAKE) && (byte_cnt >= `LEN_ONE)) begin
				next_sleep = 1'b0;
			end
		end else if (cs_rise && !busy) begin
			case (opcode)
				`OP_QUAD_ENTRY: next_quad = aligned && (byte_cnt == `LEN_ONE) ? 1'b1 : next_quad;
				`OP_QUAD_EXIT: next_quad = aligned && (byte_cnt == `LEN_ONE) ? 1'b0 : next_quad;
				`OP_UNLOCK: next_modify = aligned && (byte_cnt == `LEN_ONE) && puw_done ?
					1'b1 : next_modify;
				`OP_OTP_ENTER: next_otp_mode = aligned && (byte_cnt == `LEN_ONE) ? 1'b1 : otp_mode;
				`OP_SLEEP: next_sleep = aligned && (byte_cnt == `LEN_ONE) ? 1'b1 : next_sleep;
				`OP_RELOCK: begin
					if (aligned && (byte_cnt == `LEN_ONE)) begin
						next_modify = 1'b0;
						next_otp_mode = 1'b0;
					end
				end
				`OP_CFG_WRITE: begin
					if (may_modify && (byte_cnt == `LEN_CFG)) begin
						if (otp_mode) begin
							// one-time bits only ever set; a set enable freezes the choice
							start = 1'b1;
							next_boot_en = boot_lock_enable | cfg_data[`BOOT_EN_BIT];
							next_boot_gran = boot_lock_enable ? boot_lock_granule :
								(boot_lock_granule | cfg_data[`BOOT_GRAN_BIT]);
							next_boot_side = boot_lock_enable ? boot_lock_side :
								(boot_lock_side | cfg_data[`BOOT_SIDE_BIT]);
						end else if (pin_guarded) begin
							next_refused = 1'b1;
						end else begin
							start = 1'b1;
							next_guard = cfg_data[`ST_GUARD_HI:`ST_GUARD_LO];
							next_lock = cfg_data[`ST_LOCK];
						end
					end
				end
				`OP_SER_PROG, `OP_QUAD_PROG, `OP_SMALL_WIPE, `OP_MID_WIPE, `OP_LARGE_WIPE,
				`OP_CHIP_WIPE_A, `OP_CHIP_WIPE_B: begin
					if (may_modify && (((req_op == op_prog) && (byte_cnt >= `LEN_PROG_MIN)) ||
						((req_op == op_chip) && (byte_cnt == `LEN_ONE)) ||
						((req_op != op_prog) && (req_op != op_chip) && (byte_cnt == `LEN_ADDR)))) begin
						if (gif.refuse) begin
							next_refused = 1'b1;
						end else begin
							start = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
		case (state)
			st_idle: begin
				if (start) begin
					next_cyc_cnt = load_cyc;
					next_state = st_wait;
					if (req_op == op_prog) begin
						next_prog_base = addr[`ADDR_W-1:0];
						next_drain_idx = 9'h000;
						next_drain_total = data_cnt;
						next_state = st_drain;
					end else if (req_op != op_cfg) begin
						// one strobe: the array fills the aligned region with ones
						next_strobe = 1'b1;
						next_array_op = req_op;
						next_array_addr = addr[`ADDR_W-1:0] & ~((req_op == op_sector) ? `SECTOR_MASK :
							(req_op == op_half) ? `HALF_BLK_MASK :
							(req_op == op_block) ? `BLOCK_MASK : `ARRAY_TOP);
					end
				end
			end
			st_drain: begin
				// addresses wrap inside the page, never into the next one
				next_strobe = 1'b1;
				next_array_op = op_prog;
				next_array_addr = {prog_base[`ADDR_W-1:8], prog_base[7:0] + drain_idx[7:0]};
				next_array_data = page_buf[drain_idx[7:0]];
				next_drain_idx = drain_idx + 9'h001;
				if (drain_idx + 9'h001 >= drain_total) begin
					next_state = st_wait;
				end
			end
			st_wait: begin
				if (cyc_cnt == 32'h00000000) begin
					next_state = st_idle;
					next_modify = 1'b0;
				end else begin
					next_cyc_cnt = cyc_cnt - 32'h00000001;
				end
			end
			default: next_state = st_idle;
		endcase
		next_standby = cs_n && (next_state == st_idle) && !next_sleep;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
			cyc_cnt <= 32'h00000000;
			puw_cnt <= 32'h00000000;
			puw_done <= 1'b0;
			drain_idx <= 9'h000;
			drain_total <= 9'h000;
			prog_base <= '0;
			otp_mode <= 1'b0;
			modify_allowed_flag <= 1'b0;
			region_guard_bits <= 4'h0;
			guard_lock_flag <= 1'b0;
			all_quad_protocol <= 1'b0;
			deep_sleep <= 1'b0;
			boot_lock_enable <= 1'b0;
			boot_lock_granule <= 1'b0;
			boot_lock_side <= 1'b0;
			array_strobe <= 1'b0;
			array_op <= op_none;
			array_addr <= '0;
			array_data <= 8'h00;
			cmd_refused <= 1'b0;
			standby <= 1'b0;
			cycle_ongoing_flag <= 1'b0;
		end else begin
			state <= next_state;
			cyc_cnt <= next_cyc_cnt;
			puw_cnt <= next_puw_cnt;
			puw_done <= next_puw_done;
			drain_idx <= next_drain_idx;
			drain_total <= next_drain_total;
			prog_base <= next_prog_base;
			otp_mode <= next_otp_mode;
			modify_allowed_flag <= next_modify;
			region_guard_bits <= next_guard;
			guard_lock_flag <= next_lock;
			all_quad_protocol <= next_quad;
			deep_sleep <= next_sleep;
			boot_lock_enable <= next_boot_en;
			boot_lock_granule <= next_boot_gran;
			boot_lock_side <= next_boot_side;
			array_strobe <= next_strobe;
			array_op <= next_array_op;
			array_addr <= next_array_addr;
			array_data <= next_array_data;
			cmd_refused <= next_refused;
			standby <= next_standby;
			cycle_ongoing_flag <= (next_state != st_idle);
		end
	end
endmodule : serial_flash_write_protect_ctrl

// *** verification/flash_guard_checker.sv ***
// port assertions for the flash modify and guard control
// assumes it is bound into serial_flash_write_protect_ctrl
`timescale 1ns/1ns
module flash_guard_checker
	import flash_ctrl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// watched ports
	input wire logic cs_n,
	input wire logic [3:0] dq_in,
	input wire logic array_strobe,
	input wire logic cycle_ongoing_flag,
	input wire logic modify_allowed_flag,
	input wire logic [3:0] region_guard_bits,
	input wire logic guard_lock_flag,
	input wire logic all_quad_protocol,
	input wire logic deep_sleep,
	input wire logic standby,
	input wire logic boot_lock_enable,
	input wire logic boot_lock_granule,
	input wire logic boot_lock_side,
	input wire logic cmd_refused
);
	// ********
	// one clock domain
	// ********
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	chk_strobe_in_cycle: assert property (array_strobe |-> cycle_ongoing_flag)
		else $error("strobe outside cycle");
	chk_cycle_needs_latch: assert property ($rose(cycle_ongoing_flag)
		|-> modify_allowed_flag) else $error("cycle without latch");
	// program strobes begin one cycle after busy rises
	chk_strobe_run: assert property (array_strobe && $past(cycle_ongoing_flag, 2)
		|-> $past(array_strobe)) else $error("strobe gap in cycle");
	chk_refuse_no_cycle: assert property (cmd_refused |-> !array_strobe ##1 !array_strobe)
		else $error("refused but strobed");
	chk_latch_clear_end: assert property ($fell(cycle_ongoing_flag) |-> !modify_allowed_flag)
		else $error("latch kept after cycle");
	// standby lags the select pin by one register
	chk_active_no_standby: assert property (
		(!cs_n || cycle_ongoing_flag || deep_sleep) [*3]
		|-> !standby) else $error("standby while active");
	chk_sleep_no_modify: assert property (deep_sleep |-> !array_strobe && !cmd_refused)
		else $error("array use in sleep");
	chk_pin_guard_hold: assert property (
		(guard_lock_flag && !dq_in[2] && !all_quad_protocol) [*2]
		|-> $stable(region_guard_bits)) else $error("guard bits changed");
	chk_boot_sticky: assert property (boot_lock_enable |=> boot_lock_enable)
		else $error("boot lock cleared");
	chk_boot_freeze: assert property (boot_lock_enable
		|=> $stable({boot_lock_granule, boot_lock_side})) else $error("boot region moved");
endmodule : flash_guard_checker

bind serial_flash_write_protect_ctrl flash_guard_checker chk_inst (
	.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .dq_in(dq_in), .array_strobe(array_strobe),
	.cycle_ongoing_flag(cycle_ongoing_flag), .modify_allowed_flag(modify_allowed_flag),
	.region_guard_bits(region_guard_bits), .guard_lock_flag(guard_lock_flag),
	.all_quad_protocol(all_quad_protocol), .deep_sleep(deep_sleep), .standby(standby),
	.boot_lock_enable(boot_lock_enable), .boot_lock_granule(boot_lock_granule),
	.boot_lock_side(boot_lock_side), .cmd_refused(cmd_refused)
);

// *** verification/spi_host_model.sv ***
// host controller model driving the serial pins of the flash control
// assumes the bench fills tx and calls run; mode 0, clock idle low
`timescale 1ns/1ns
module spi_host_model (
	// pacing clock
	input wire logic sys_clk,
	// serial pins
	output logic spi_clk,
	output logic cs_n,
	output logic [3:0] dq_in
);
	logic [7:0] tx[$];
	logic quad = 1'b0;
	logic wp_n = 1'b1;
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		dq_in = 4'hA;
	end
	// ********
	// frame tasks
	// ********
	// four-cycle half period: every edge is seen
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic pulse;
		tick(4);
		spi_clk = 1'b1;
		tick(4);
		spi_clk = 1'b0;
	endtask : pulse
	// whole bytes msb first, then stray clocks
	task automatic run(input int extra);
		logic [7:0] b;
		cs_n = 1'b0;
		foreach (tx[i]) begin
			b = tx[i];
			for (int k = 7; k >= 0; k = k - (quad ? 4 : 1)) begin
				dq_in = quad ? b[k -: 4] : {1'b1, wp_n, 1'b1, b[k]};
				pulse;
			end
		end
		repeat (extra) pulse;
		tick(4);
		cs_n = 1'b1;
		// released data line shows no stale bit
		dq_in = {1'b1, wp_n, 1'b1, ~dq_in[0]};
		tick(8);
		tx.delete();
	endtask : run
endmodule : spi_host_model

// *** verification/testbench.sv ***
// self-checking bench for the flash modify and guard control
// assumes the host model drives the pins; cycle times are shortened
`timescale 1ns/1ns
module testbench;
	import flash_ctrl_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	wire spi_clk, cs_n;
	wire [3:0] dq_in;
	logic array_strobe, busy, mod_ok, quad, sleep, stby, boot_en, boot_gr, boot_sd, refused, lock;
	logic [3:0] guard, dq_oe;
	logic [3:0] codes[5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'h3};
	logic [7:0] wipe[4] = '{8'h20, 8'h52, 8'hD8, 8'hC7};
	op_kind_t kinds[4] = '{op_sector, op_half, op_block, op_chip};
	logic [16:0] array_addr, first_addr, last_addr;
	logic [7:0] array_data, last_data;
	op_kind_t array_op, last_op;
	int error_cnt = 0;
	int n_tests = 0;
	int n_strobe = 0;
	int n_ref = 0;
	always #5 sys_clk = ~sys_clk;

	serial_flash_write_protect_ctrl #(.CLK_MHZ(1), .T_CHIP_US(1000)) DUT (
		.sys_clk(sys_clk), .resetn(resetn), .spi_clk(spi_clk), .cs_n(cs_n), .dq_in(dq_in),
		.dq_out(), .dq_oe(dq_oe), .array_strobe(array_strobe), .array_op(array_op),
		.array_addr(array_addr), .array_data(array_data), .cycle_ongoing_flag(busy),
		.modify_allowed_flag(mod_ok), .region_guard_bits(guard), .guard_lock_flag(lock),
		.all_quad_protocol(quad), .deep_sleep(sleep), .standby(stby), .boot_lock_enable(boot_en),
		.boot_lock_granule(boot_gr), .boot_lock_side(boot_sd), .cmd_refused(refused));
	spi_host_model host (.sys_clk(sys_clk), .spi_clk(spi_clk), .cs_n(cs_n), .dq_in(dq_in));

	// log array traffic and refusals
	always @(posedge sys_clk) begin
		if (array_strobe === 1'b1) begin
			if (n_strobe == 0) first_addr <= array_addr;
			n_strobe <= n_strobe + 1;
			last_addr <= array_addr;
			last_data <= array_data;
			last_op <= array_op;
		end
		if (refused === 1'b1) n_ref <= n_ref + 1;
	end

	// ********
	// access tasks
	// ********
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic frame(input int extra);
		n_strobe = 0;
		n_ref = 0;
		host.run(extra);
	endtask : frame
	task automatic cmd(input logic [7:0] op);
		host.tx = '{op};
		frame(0);
	endtask : cmd
	// bounded, a stuck busy fails the next compare
	task automatic wait_idle;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) host.tick(1);
		host.tick(2);
	endtask : wait_idle
	task automatic cfg(input logic [7:0] d);
		cmd(8'h06);
		host.tx = '{8'h01, d};
		frame(0);
		wait_idle;
	endtask : cfg
	task automatic erase(input logic [7:0] op, input op_kind_t k, input logic [16:0] a, input logic ok);
		cmd(8'h06);
		host.tx = '{op, {7'h00, a[16]}, a[15:8], a[7:0]};
		if (op == 8'hC7) host.tx = '{op};
		frame(0);
		check("busy", busy, ok);
		check("refusals", n_ref, !ok);
		check("strobes", n_strobe, ok);
		if (ok) begin
			check("op", last_op, k);
			if (op != 8'hC7) check("base", first_addr, a);
			host.tx = '{8'h20, 8'h00, 8'h00, 8'h00};
			frame(0);
			check("in cycle", n_strobe, 0);
		end
		wait_idle;
		check("latch", mod_ok, !ok);
		check("standby", stby, 1);
		check("drive", dq_oe, 4'h0);
	endtask : erase
	function automatic logic prot(input logic [3:0] c, input logic hi);
		if (c[2:0] == 3'h0) return 1'b0;
		if (c[2:0] == 3'h1) return c[3] ^ hi;
		return 1'b1;
	endfunction : prot
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// ********
	// tests
	// ********
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 resetn = 1'b1;
		host.tick(2);
		cmd(8'h06);
		check("early latch", mod_ok, 0);
		host.tick(1000);
		host.tx = '{8'h20, 8'h00, 8'h00, 8'h00};
		frame(0);
		check("no latch", n_strobe, 0);
		cmd(8'h06);
		check("latch set", mod_ok, 1);
		host.tx = '{8'h20, 8'h00, 8'h00, 8'h00};
		frame(1);
		check("odd clocks", busy, 0);
		$display("test latch done");
		foreach (wipe[i]) erase(wipe[i], kinds[i], 17'h10000, 1'b1);
		$display("test erase done");
		cmd(8'h06);
		host.tx = '{8'h02, 8'h00, 8'h00, 8'hFE, 8'hAA, 8'h55, 8'h0F};
		frame(0);
		check("prog count", n_strobe, 3);
		check("prog first", first_addr, 17'h000FE);
		check("prog wrap", last_addr, 17'h00000);
		check("prog data", last_data, 8'h0F);
		check("prog op", last_op, op_prog);
		wait_idle;
		check("prog latch", mod_ok, 0);
		$display("test program done");
		foreach (codes[i]) begin
			cfg({2'b00, codes[i], 2'b00});
			check("guard", guard, codes[i]);
			erase(8'h20, op_sector, 17'h00000, !prot(codes[i], 1'b0));
			erase(8'h20, op_sector, 17'h10000, !prot(codes[i], 1'b1));
		end
		cfg(8'h80);
		host.wp_n = 1'b0;
		cfg(8'h3C);
		check("pin refuse", n_ref, 1);
		check("guard held", guard, 4'h0);
		host.wp_n = 1'b1;
		cfg(8'h00);
		check("lock off", lock, 0);
		$display("test guard done");
		cmd(8'h06);
		cmd(8'hB9);
		check("sleep", sleep, 1);
		cmd(8'h04);
		check("sleep latch", mod_ok, 1);
		cmd(8'hAB);
		check("wake", sleep, 0);
		cmd(8'h38);
		check("quad on", quad, 1);
		host.quad = 1'b1;
		cmd(8'h04);
		check("relock", mod_ok, 0);
		cmd(8'h06);
		check("quad latch", mod_ok, 1);
		cmd(8'hFF);
		host.quad = 1'b0;
		check("quad off", quad, 0);
		$display("test sleep and quad done");
		cmd(8'h3A);
		cfg(8'h18);
		cmd(8'h04);
		check("boot bits", {boot_en, boot_gr, boot_sd}, 3'h6);
		erase(8'h20, op_sector, 17'h1F000, 1'b0);
		erase(8'h20, op_sector, 17'h1E000, 1'b1);
		$display("test boot lock done");
		end_of_test;
	end
	// run needs about 30000 cycles
	initial begin
		repeat (90000) @(posedge sys_clk);
		error_cnt++;
		end_of_test;
	end
endmodule : testbench
